// ==== occ_cfg.svh ====
// How it works
// [RULE1] PLL output divider code 000..111 divides by 1,2,4,..,64,256; bits 29-27
// [RULE2] Fast RC divider code 000..111 divides likewise; bits 26-24, resets to 001
// [RULE3] Bit 22 reads one only while secondary oscillator is enabled and stable
// [RULE4] Bit 21 shows divisor ready; divisor writes are dropped while it is zero
// [RULE5] Peripheral bus clock is system clock over 1,2,4,8; bits 20-19, default 11
// [RULE6] Clear alias at base plus 0x4 clears written one bits; reads give zero
// [RULE7] Set alias at base plus 0x8 sets written one bits
// [RULE8] Invert alias at base plus 0xC toggles written one bits
// [RULE9] Control register writes are rejected unless the unlock key pair came first
// [RULE10] Reading the control register clears the clock fail flag
// [RULE11] Configuration marked fields load from configuration words after power-on reset
// [RULE12] Bits 31-30 and 23 read zero and ignore writes
// [RULE13] Fail-safe monitor watches oscillator activity and records its loss
// [RULE14] Source select codes: fast RC, fast RC PLL, primary, primary PLL, secondary, etc
// [RULE15] Switch enable starts a move to the new source; reads zero when done
// [RULE16] Clock fail flag sets on a detected failure, otherwise reads zero
// [RULE17] PLL lock reads one when locked or start timer expired, zero if PLL unused
// [RULE18] Peripheral bus divisor changes take effect only on period boundaries; source switches use a fixed four-cycle hold instead
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH
`define OCC_CLK_NS        20
`define OCC_CTRL_BASE     8'h00
`define OCC_TUNE_BASE     8'h10
`define OCC_CFG1_ADDR     8'h20
`define OCC_CFG2_ADDR     8'h24
`define OCC_KEY_ADDR      8'h30
`define OCC_KEY_FIRST     32'h5A5A_0F0F
`define OCC_KEY_SECOND    32'hA5A5_F0F0
`define OCC_CTRL_WMASK    32'h3F1F_079F
`define OCC_PERIPH_BUS_DIVISOR_MASK    32'h0018_0000
`define OCC_TUNE_WMASK    32'h0000_003F
`define OCC_CTRL_RST      32'h0118_0000
`define OCC_PLL_OUTPUT_DIVIDER       29:27
`define OCC_FAST_RC_DIVIDER        26:24
`define OCC_SECONDARY_OSC_READY_BIT   22
`define OCC_DIVRDY_BIT    21
`define OCC_PERIPH_BUS_DIVISOR         20:19
`define OCC_PLLMULT       18:16
`define OCC_CURSRC        14:12
`define OCC_NEWSRC        10:8
`define OCC_LOCK_BIT      5
`define OCC_FAIL_BIT      3
`define OCC_SOSCEN_BIT    1
`define OCC_SWEN_BIT      0
`define OCC_CFG1_NEWSRC   2:0
`define OCC_CFG1_SOSCEN   5
`define OCC_CFG1_PERIPH_BUS_DIVISOR    13:12
`define OCC_CFG2_PLL_OUTPUT_DIVIDER  18:16
`define OCC_CFG2_PLLMULT  6:4
`define OCC_SRC_FRC       3'h0
`define OCC_SRC_FRC_PLL   3'h1
`define OCC_SRC_PRI_PLL   3'h3
`define OCC_PLL_START_NS  50000
`define OCC_FAIL_NS       1000
`define OCC_SWITCH_CYC    3'h4
`define OCC_CFG_SETTLE    2'h2
`define OCC_PERIPH_BUS_DIVISOR_RST     2'h3
`define OCC_PLL_RATIO_RST 9'h001
`define OCC_FRC_RATIO_RST 9'h002
`endif

// ==== occ_pkg.sv ====
package occ_pkg;
	typedef enum logic [1:0] {
		OCC_SW_IDLE = 2'b00,
		OCC_SW_HOLD = 2'b01,
		OCC_SW_DONE = 2'b10
	} occ_sw_state_t;
	typedef enum logic [1:0] {
		OCC_OP_WRITE = 2'b00,
		OCC_OP_CLR   = 2'b01,
		OCC_OP_SET   = 2'b10,
		OCC_OP_INV   = 2'b11
	} occ_op_t;
	function automatic logic [8:0] occ_div_ratio(input logic [2:0] code);
		occ_div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
	endfunction
	function automatic logic occ_hit(input logic [7:0] addr, input logic [7:0] base);
		occ_hit = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
	endfunction
	function automatic logic [31:0] occ_alias_apply(input occ_op_t op,
		input logic [31:0] old, input logic [31:0] wd, input logic [31:0] mask);
		case (op)
			OCC_OP_CLR: occ_alias_apply = old & ~(wd & mask);
			OCC_OP_SET: occ_alias_apply = old | (wd & mask);
			OCC_OP_INV: occ_alias_apply = old ^ (wd & mask);
			default:    occ_alias_apply = (old & ~mask) | (wd & mask);
		endcase
	endfunction
endpackage

// ==== occ_div_if.sv ====
`timescale 1ns/1ns
interface occ_div_if;
	logic [1:0] divisor;
	logic       load;
	logic       ready;
	logic       tick;
	modport ctrl (output divisor, output load, input ready, input tick);
	modport div  (input divisor, input load, output ready, output tick);
endinterface

// ==== occ_periph_bus_clock_div.sv ====
`timescale 1ns/1ns
`include "occ_cfg.svh"
module occ_periph_bus_clock_div
	import occ_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	occ_div_if.div    dv
);
	logic [1:0] cur_r;
	logic [1:0] pend_val_r;
	logic       pend_r;
	logic [2:0] cnt_r;
	logic       tick_r;
	logic [2:0] period_m1;

	// New divisor waits for the wrap so no short period leaks out
	assign period_m1 = pend_r ? ((3'h1 << pend_val_r) - 3'h1) : ((3'h1 << cur_r) - 3'h1); // [RULE5]
	assign dv.ready = ~pend_r; // [RULE4]
	assign dv.tick = tick_r;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur_r <= `OCC_PERIPH_BUS_DIVISOR_RST;
			pend_r <= 1'b0;
			pend_val_r <= `OCC_PERIPH_BUS_DIVISOR_RST;
		end else if (dv.load && !pend_r) begin
			pend_r <= 1'b1;
			pend_val_r <= dv.divisor;
		end else if (pend_r && cnt_r == 3'h0) begin
			cur_r <= pend_val_r; // [RULE18]
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_r <= 3'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (cnt_r == 3'h0);
			cnt_r <= (cnt_r == 3'h0) ? period_m1 : cnt_r - 3'h1;
		end
	end

	chk_div_busy_after_load: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE4]
		dv.load && dv.ready |=> !dv.ready)
		else $error("divisor ready did not drop after load");
	chk_div_tick_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE5]
		tick_r && cur_r == 2'h1 && !pend_r |=> !tick_r)
		else $error("divide by two ticked back to back");
endmodule

// ==== occ_osc_ctrl.sv ====
`timescale 1ns/1ns
`include "occ_cfg.svh"
module occ_osc_ctrl
	import occ_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic [31:0] i_cfg_word_one,
	input  wire logic [31:0] i_cfg_word_two,
	input  wire logic        i_sosc_stable,
	input  wire logic        i_pll_locked,
	input  wire logic        i_osc_activity,
	output logic             o_periph_bus_clock_en,
	output logic      [2:0]  o_current_source,
	output logic      [8:0]  o_pll_div_ratio,
	output logic      [8:0]  o_frc_div_ratio,
	output logic      [2:0]  o_pll_mult,
	output logic             o_sosc_enable,
	output logic      [5:0]  o_fast_rc_tuning,
	output logic             o_clock_fail
);
	localparam int PLL_START_CYC = `OCC_PLL_START_NS / `OCC_CLK_NS;
	localparam int FAIL_CYC = `OCC_FAIL_NS / `OCC_CLK_NS;

	occ_div_if div_if ();

	occ_periph_bus_clock_div u_periph_bus_clock_div (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.dv        (div_if)
	);

	logic [31:0]   ctrl_r;
	logic [31:0]   ctrl_nxt;
	logic [31:0]   ctrl_wval;
	logic [31:0]   ctrl_mask;
	logic [5:0]    tune_r;
	logic [31:0]   tune_wval;
	logic [31:0]   cfg1_s1_r;
	logic [31:0]   cfg1_r;
	logic [31:0]   cfg2_s1_r;
	logic [31:0]   cfg2_r;
	logic [2:0]    pin_s1_r;
	logic [2:0]    pin_s2_r;
	logic          act_d_r;
	logic [1:0]    cfg_wait_r;
	logic          cfg_done_r;
	logic          cfg_load;
	logic          key_stage_r;
	logic          unlocked_r;
	logic          ctrl_wr;
	logic          tune_wr;
	logic          ctrl_rd;
	logic [31:0]   ctrl_view;
	logic [31:0]   rdata_r;
	logic [2:0]    cur_src_r;
	logic          sosc_ready_r;
	logic          pll_lock_r;
	logic          pll_in_use;
	logic [11:0]   pll_timer_r;
	logic          pll_expired_r;
	logic [6:0]    fail_cnt_r;
	logic          fail_seen_r;
	logic          fail_evt;
	occ_sw_state_t sw_state_r;
	logic [2:0]    sw_cnt_r;
	logic          sw_done;
	logic          rd_base_q_r;
	logic          periph_en_r;

	// Two stages on everything that comes from pins or nonvolatile storage
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg1_s1_r <= 32'h0000_0000;
			cfg1_r <= 32'h0000_0000;
			cfg2_s1_r <= 32'h0000_0000;
			cfg2_r <= 32'h0000_0000;
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			act_d_r <= 1'b0;
		end else begin
			cfg1_s1_r <= i_cfg_word_one;
			cfg1_r <= cfg1_s1_r;
			cfg2_s1_r <= i_cfg_word_two;
			cfg2_r <= cfg2_s1_r;
			pin_s1_r <= {i_osc_activity, i_pll_locked, i_sosc_stable};
			pin_s2_r <= pin_s1_r;
			act_d_r <= pin_s2_r[2];
		end
	end

	// Configuration words are caught once the synchronisers have settled
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_wait_r <= 2'h0;
			cfg_done_r <= 1'b0;
		end else if (!cfg_done_r) begin
			cfg_wait_r <= cfg_wait_r + 2'h1;
			cfg_done_r <= (cfg_wait_r == `OCC_CFG_SETTLE);
		end
	end
	assign cfg_load = !cfg_done_r && (cfg_wait_r == `OCC_CFG_SETTLE); // [RULE11]

	// Unlock: first key then second key on the key address; any other key relocks
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			key_stage_r <= 1'b0;
			unlocked_r <= 1'b0;
		end else if (i_wr && i_addr == `OCC_KEY_ADDR) begin
			key_stage_r <= (i_wdata == `OCC_KEY_FIRST);
			unlocked_r <= key_stage_r && (i_wdata == `OCC_KEY_SECOND); // [RULE9]
		end else if (i_wr) begin
			key_stage_r <= 1'b0;
		end
	end

	assign ctrl_wr = i_wr && occ_hit(i_addr, `OCC_CTRL_BASE) && unlocked_r; // [RULE9]
	assign tune_wr = i_wr && occ_hit(i_addr, `OCC_TUNE_BASE) && unlocked_r;
	assign ctrl_rd = i_rd && i_addr == `OCC_CTRL_BASE;
	// Divisor bits drop out of the write mask while the divider is busy
	assign ctrl_mask = div_if.ready ? `OCC_CTRL_WMASK
		: (`OCC_CTRL_WMASK & ~`OCC_PERIPH_BUS_DIVISOR_MASK); // [RULE4] [RULE12]
	assign ctrl_wval = occ_alias_apply(occ_op_t'(i_addr[3:2]), ctrl_r, i_wdata,
		ctrl_mask); // [RULE6] [RULE7] [RULE8]
	assign tune_wval = occ_alias_apply(occ_op_t'(i_addr[3:2]), {26'h000_0000, tune_r},
		i_wdata, `OCC_TUNE_WMASK);

	always_comb begin
		ctrl_nxt = ctrl_wr ? ctrl_wval : ctrl_r;
		if (cfg_load) begin
			ctrl_nxt[`OCC_PLL_OUTPUT_DIVIDER] = cfg2_r[`OCC_CFG2_PLL_OUTPUT_DIVIDER]; // [RULE11]
			ctrl_nxt[`OCC_PLLMULT] = cfg2_r[`OCC_CFG2_PLLMULT];
			ctrl_nxt[`OCC_PERIPH_BUS_DIVISOR] = cfg1_r[`OCC_CFG1_PERIPH_BUS_DIVISOR];
			ctrl_nxt[`OCC_NEWSRC] = cfg1_r[`OCC_CFG1_NEWSRC];
			ctrl_nxt[`OCC_SOSCEN_BIT] = cfg1_r[`OCC_CFG1_SOSCEN];
		end
		if (sw_done) begin
			ctrl_nxt[`OCC_SWEN_BIT] = 1'b0; // [RULE15]
		end
		// A failure in the read cycle is kept: set beats the read clear
		if (ctrl_rd && !ctrl_wr) begin
			ctrl_nxt[`OCC_FAIL_BIT] = 1'b0; // [RULE10]
		end
		if (fail_evt) begin
			ctrl_nxt[`OCC_FAIL_BIT] = 1'b1; // [RULE16]
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_r <= `OCC_CTRL_RST; // [RULE2] [RULE5]
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	assign div_if.divisor = ctrl_nxt[`OCC_PERIPH_BUS_DIVISOR];
	assign div_if.load = ctrl_nxt[`OCC_PERIPH_BUS_DIVISOR] != ctrl_r[`OCC_PERIPH_BUS_DIVISOR]; // [RULE5]

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tune_r <= 6'h00;
		end else if (tune_wr) begin
			tune_r <= tune_wval[5:0];
		end
	end

	// Clock switch: hold a few cycles so both sources meet a safe edge
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sw_state_r <= OCC_SW_IDLE;
			sw_cnt_r <= 3'h0;
		end else begin
			case (sw_state_r)
				OCC_SW_IDLE: begin
					sw_cnt_r <= 3'h0;
					if (ctrl_r[`OCC_SWEN_BIT]) begin
						sw_state_r <= OCC_SW_HOLD; // [RULE15]
					end
				end
				OCC_SW_HOLD: begin
					sw_cnt_r <= sw_cnt_r + 3'h1;
					if (sw_cnt_r == `OCC_SWITCH_CYC - 3'h1) begin
						sw_state_r <= OCC_SW_DONE; // [RULE18]
					end
				end
				OCC_SW_DONE: sw_state_r <= OCC_SW_IDLE;
				default: sw_state_r <= OCC_SW_IDLE;
			endcase
		end
	end
	assign sw_done = sw_state_r == OCC_SW_DONE;

	// Fail-safe fallback to fast RC outranks a switch completing in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur_src_r <= `OCC_SRC_FRC;
		end else if (fail_evt) begin
			cur_src_r <= `OCC_SRC_FRC; // [RULE13] [RULE14]
		end else if (cfg_load) begin
			cur_src_r <= cfg1_r[`OCC_CFG1_NEWSRC]; // [RULE11]
		end else if (sw_done) begin
			cur_src_r <= ctrl_r[`OCC_NEWSRC]; // [RULE14] [RULE15]
		end
	end

	// Activity monitor: no edge for the fail window means the clock died
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fail_cnt_r <= 7'h00;
			fail_seen_r <= 1'b0;
		end else if (pin_s2_r[2] != act_d_r) begin
			fail_cnt_r <= 7'h00;
			fail_seen_r <= 1'b0;
		end else if (fail_cnt_r != 7'(FAIL_CYC - 1)) begin
			fail_cnt_r <= fail_cnt_r + 7'h01;
		end else begin
			fail_seen_r <= 1'b1; // [RULE13]
		end
	end
	assign fail_evt = (fail_cnt_r == 7'(FAIL_CYC - 1)) && !fail_seen_r
		&& (pin_s2_r[2] == act_d_r); // [RULE13]

	assign pll_in_use = cur_src_r == `OCC_SRC_FRC_PLL || cur_src_r == `OCC_SRC_PRI_PLL;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pll_timer_r <= 12'h000;
			pll_expired_r <= 1'b0;
		end else if (!pll_in_use) begin
			pll_timer_r <= 12'h000;
			pll_expired_r <= 1'b0;
		end else if (pll_timer_r == 12'(PLL_START_CYC - 1)) begin
			pll_expired_r <= 1'b1;
		end else begin
			pll_timer_r <= pll_timer_r + 12'h001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pll_lock_r <= 1'b0;
			sosc_ready_r <= 1'b0;
		end else begin
			pll_lock_r <= pll_in_use && (pin_s2_r[1] || pll_expired_r); // [RULE17]
			sosc_ready_r <= ctrl_r[`OCC_SOSCEN_BIT] && pin_s2_r[0]; // [RULE3]
		end
	end

	always_comb begin
		ctrl_view = ctrl_r & `OCC_CTRL_WMASK; // [RULE12]
		ctrl_view[`OCC_SECONDARY_OSC_READY_BIT] = sosc_ready_r; // [RULE3]
		ctrl_view[`OCC_DIVRDY_BIT] = div_if.ready; // [RULE4]
		ctrl_view[`OCC_CURSRC] = cur_src_r;
		ctrl_view[`OCC_LOCK_BIT] = pll_lock_r; // [RULE17]
	end

	// Alias addresses read as zero
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_r <= 32'h0000_0000;
			rd_base_q_r <= 1'b0;
		end else begin
			rd_base_q_r <= ctrl_rd;
			if (!i_rd) begin
				rdata_r <= 32'h0000_0000;
			end else begin
				case (i_addr)
					`OCC_CTRL_BASE: rdata_r <= ctrl_view; // [RULE6]
					`OCC_TUNE_BASE: rdata_r <= {26'h000_0000, tune_r};
					`OCC_CFG1_ADDR: rdata_r <= cfg1_r;
					`OCC_CFG2_ADDR: rdata_r <= cfg2_r;
					`OCC_KEY_ADDR:  rdata_r <= {31'h0000_0000, unlocked_r};
					default:        rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pll_div_ratio <= `OCC_PLL_RATIO_RST;
			o_frc_div_ratio <= `OCC_FRC_RATIO_RST;
			o_pll_mult <= 3'h0;
			o_sosc_enable <= 1'b0;
			o_clock_fail <= 1'b0;
			periph_en_r <= 1'b0;
		end else begin
			o_pll_div_ratio <= occ_div_ratio(ctrl_r[`OCC_PLL_OUTPUT_DIVIDER]); // [RULE1]
			o_frc_div_ratio <= occ_div_ratio(ctrl_r[`OCC_FAST_RC_DIVIDER]); // [RULE2]
			o_pll_mult <= ctrl_r[`OCC_PLLMULT];
			o_sosc_enable <= ctrl_r[`OCC_SOSCEN_BIT];
			o_clock_fail <= ctrl_r[`OCC_FAIL_BIT]; // [RULE16]
			periph_en_r <= div_if.tick;
		end
	end

	assign o_rdata = rdata_r;
	assign o_current_source = cur_src_r;
	assign o_fast_rc_tuning = tune_r;
	assign o_periph_bus_clock_en = periph_en_r;

	sequence s_sw_request;
		sw_state_r == OCC_SW_IDLE && ctrl_r[`OCC_SWEN_BIT] && !ctrl_wr;
	endsequence
	sequence s_sw_finished;
		!ctrl_r[`OCC_SWEN_BIT] && sw_state_r == OCC_SW_IDLE;
	endsequence

	chk_switch_completes: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE15]
		s_sw_request ##1 !ctrl_wr [*6] |-> ##0 s_sw_finished)
		else $error("switch enable not cleared after switch");
	chk_fail_read_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE10]
		ctrl_rd && !ctrl_wr && !fail_evt |=> !ctrl_r[`OCC_FAIL_BIT])
		else $error("clock fail flag survived a read");
	chk_fail_flag_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE16]
		fail_evt |=> ctrl_r[`OCC_FAIL_BIT] ##1 o_clock_fail)
		else $error("clock fail flag not set on failure");
	chk_lock_rejects: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE9]
		i_wr && occ_hit(i_addr, `OCC_CTRL_BASE) && !unlocked_r && !cfg_load
		|=> $stable(ctrl_r[`OCC_FAST_RC_DIVIDER]))
		else $error("locked control write took effect");
	chk_divisor_guard: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE4]
		!div_if.ready && !cfg_load |=> $stable(ctrl_r[`OCC_PERIPH_BUS_DIVISOR]))
		else $error("divisor changed while not ready");
	chk_sosc_needs_en: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE3]
		sosc_ready_r |-> $past(ctrl_r[`OCC_SOSCEN_BIT]) && $past(pin_s2_r[0]))
		else $error("secondary ready without enabled stable oscillator");
	chk_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE12]
		rd_base_q_r |-> o_rdata[31:30] == 2'h0 && !o_rdata[23])
		else $error("reserved control bits read nonzero");
	chk_alias_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE7]
		ctrl_wr && i_addr[3:2] == 2'h2 && i_wdata[24] && !cfg_load |=> ctrl_r[24])
		else $error("set alias did not set bit");
	chk_alias_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE6]
		ctrl_wr && i_addr[3:2] == 2'h1 && i_wdata[25] && !cfg_load |=> !ctrl_r[25])
		else $error("clear alias did not clear bit");
	chk_lock_unused: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE17]
		!pll_in_use ##1 !pll_in_use |-> !pll_lock_r)
		else $error("PLL lock shown while PLL unused");
endmodule

// ==== tb_occ_osc_ctrl.sv ====
`timescale 1ns/1ns
`include "occ_cfg.svh"
module tb_occ_osc_ctrl
	import occ_pkg::*;
;
	logic        i_clk_sys;
	logic        i_reset_n;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic        i_sosc_stable;
	logic        i_pll_locked;
	logic        i_osc_activity;
	logic        o_periph_bus_clock_en;
	logic [2:0]  o_current_source;
	logic [8:0]  o_pll_div_ratio;
	logic [8:0]  o_frc_div_ratio;
	logic [2:0]  o_pll_mult;
	logic        o_sosc_enable;
	logic [5:0]  o_fast_rc_tuning;
	logic        o_clock_fail;
	logic        act_on;
	int          error_cnt;
	int          checked;
	int          cyc;
	int          n;
	logic [1:0]  cur;

	// New source 000, secondary enabled, divisor 10; PLL out div 011, mult 010
	localparam logic [31:0] CFG_ONE = 32'h0000_2020;
	localparam logic [31:0] CFG_TWO = 32'h0003_0020;

	occ_osc_ctrl dut (
		.i_clk_sys            (i_clk_sys),
		.i_reset_n            (i_reset_n),
		.i_addr               (i_addr),
		.i_wdata              (i_wdata),
		.i_wr                 (i_wr),
		.i_rd                 (i_rd),
		.o_rdata              (o_rdata),
		.i_cfg_word_one       (CFG_ONE),
		.i_cfg_word_two       (CFG_TWO),
		.i_sosc_stable        (i_sosc_stable),
		.i_pll_locked         (i_pll_locked),
		.i_osc_activity       (i_osc_activity),
		.o_periph_bus_clock_en(o_periph_bus_clock_en),
		.o_current_source     (o_current_source),
		.o_pll_div_ratio      (o_pll_div_ratio),
		.o_frc_div_ratio      (o_frc_div_ratio),
		.o_pll_mult           (o_pll_mult),
		.o_sosc_enable        (o_sosc_enable),
		.o_fast_rc_tuning     (o_fast_rc_tuning),
		.o_clock_fail         (o_clock_fail)
	);

	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Activity toggles stand in for a live oscillator; stopping them fakes a failure
	always @(posedge i_clk_sys) begin
		if (act_on) begin
			i_osc_activity <= ~i_osc_activity;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata & m, e);
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge i_clk_sys);
		#1;
	endtask

	// Cycles between two enable pulses, bounded so a dead divider cannot hang
	task automatic period(output int p);
		int k;
		k = 0;
		#1;
		while (o_periph_bus_clock_en !== 1'b1 && k < 50) begin
			@(posedge i_clk_sys);
			#1;
			k++;
		end
		p = 0;
		do begin
			@(posedge i_clk_sys);
			#1;
			p++;
		end while (o_periph_bus_clock_en !== 1'b1 && p < 50);
	endtask

	function automatic logic [31:0] ratio(input int c);
		ratio = (c == 7) ? 32'h0000_0100 : (32'h0000_0001 << c);
	endfunction

	initial begin
		i_reset_n      = 1'b0;
		i_addr         = 8'h00;
		i_wdata        = 32'h0000_0000;
		i_wr           = 1'b0;
		i_rd           = 1'b0;
		i_sosc_stable  = 1'b0;
		i_pll_locked   = 1'b0;
		i_osc_activity = 1'b0;
		act_on         = 1'b1;
		error_cnt      = 0;
		checked        = 0;
		cyc            = 0;
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		#1;
		chk(32'(o_frc_div_ratio), 32'h0000_0002);
		chk(32'(o_pll_div_ratio), 32'h0000_0001);
		idle(16);
		rd(8'h00, 32'hFFFF_FFFF, 32'h1932_0002);
		chk(32'(o_sosc_enable), 32'h0000_0001);
		idle(1);
		chk(o_rdata, 32'h0000_0000);
		chk(32'(o_pll_div_ratio), 32'h0000_0008);
		chk(32'(o_pll_mult), 32'h0000_0002);
		rd(8'h20, 32'hFFFF_FFFF, CFG_ONE);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		// Locked: base and alias writes must both bounce
		wr(8'h00, 32'h0000_0000);
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h00, 32'hFFFF_FFFF, 32'h1932_0002);
		wr(8'h30, `OCC_KEY_FIRST);
		wr(8'h30, `OCC_KEY_SECOND);
		rd(8'h30, 32'h0000_0001, 32'h0000_0001);
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 32'h3800_0000);
			wr(8'h08, 32'(c) << 27);
			idle(3);
			chk(32'(o_pll_div_ratio), ratio(c));
			rd(8'h00, 32'h3800_0000, 32'(c) << 27);
			wr(8'h04, 32'h0700_0000);
			wr(8'h08, 32'(c) << 24);
			idle(3);
			chk(32'(o_frc_div_ratio), ratio(c));
		end
		wr(8'h08, 32'hC080_0000);
		rd(8'h00, 32'hC080_0000, 32'h0000_0000);
		rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
		// Secondary oscillator: toggle enable, then stable pin
		wr(8'h0C, 32'h0000_0002);
		idle(3);
		chk(32'(o_sosc_enable), 32'h0000_0000);
		i_sosc_stable <= 1'b1;
		idle(6);
		rd(8'h00, 32'h0040_0002, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0002);
		idle(6);
		rd(8'h00, 32'h0040_0002, 32'h0040_0002);
		i_sosc_stable <= 1'b0;
		idle(6);
		rd(8'h00, 32'h0040_0002, 32'h0000_0002);
		wr(8'h10, 32'h0000_00FF);
		idle(2);
		chk(32'(o_fast_rc_tuning), 32'h0000_003F);
		rd(8'h10, 32'hFFFF_FFFF, 32'h0000_003F);
		// Divisor 10 -> 11, then a change timed just after a pulse
		wr(8'h0C, 32'h0008_0000);
		idle(20);
		period(n);
		wr(8'h0C, 32'h0018_0000);
		// Divisor still busy here, so this set must be dropped
		wr(8'h08, 32'h0008_0000);
		// Four edges have passed since the last pulse; the old period must run out
		n = 4;
		#1;
		while (o_periph_bus_clock_en !== 1'b1 && n < 50) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		chk(32'(n), 32'h0000_0008);
		idle(20);
		rd(8'h00, 32'h0038_0000, 32'h0020_0000);
		cur = 2'b00;
		for (int c = 0; c < 4; c++) begin
			if (2'(c) != cur) begin
				wr(8'h0C, 32'(cur ^ 2'(c)) << 19);
			end
			cur = 2'(c);
			idle(20);
			period(n);
			chk(32'(n), 32'h0000_0001 << c);
			rd(8'h00, 32'h0038_0000, 32'h0020_0000 | (32'(c) << 19));
		end
		// Every source code through a switch; PLL codes report lock from the pin
		i_pll_locked <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 32'h0000_0700);
			wr(8'h08, 32'(c) << 8);
			wr(8'h08, 32'h0000_0001);
			idle(12);
			chk(32'(o_current_source), 32'(c));
			rd(8'h00, 32'h0000_7721, (32'(c) << 12) | (32'(c) << 8) |
				((c == 1 || c == 3) ? 32'h0000_0020 : 32'h0000_0000));
		end
		// Stop activity: fail flag, forced fast RC, read clears the flag
		act_on <= 1'b0;
		idle(80);
		chk(32'(o_clock_fail), 32'h0000_0001);
		chk(32'(o_current_source), 32'h0000_0000);
		act_on <= 1'b1;
		idle(4);
		rd(8'h00, 32'h0000_0008, 32'h0000_0008);
		idle(4);
		rd(8'h00, 32'h0000_0008, 32'h0000_0000);
		chk(32'(o_clock_fail), 32'h0000_0000);
		// Relock with the first key; the clear must then bounce
		wr(8'h30, `OCC_KEY_FIRST);
		wr(8'h04, 32'h3800_0000);
		rd(8'h00, 32'h3800_0000, 32'h3800_0000);
		wrap_up();
	end
endmodule
